//--- rtl/phyirq_regs.sv
// Physical-layer interrupt, error counter and 100 Mb/s PCS configuration registers
//
// Contract
// - Interrupt sources are link change, jabber, remote fault, autoneg done, counter half-full.
// - Event interrupts occur only while the event interrupt enable bit is one.
// - Test interrupt bit set raises an interrupt at the end of every register read.
// - Test interrupt works regardless of the event interrupt enable bit.
// - Pending flag reads one while pending, read-only, cleared by the read returning it.
// - Status bits 14 to 9 mask link, jabber, fault, autoneg, false-carrier, rx-error.
// - Reserved bits read zero and ignore writes.
// - False-carrier counter adds one per false carrier, sticking at its maximum.
// - Both counters reset to zero, are writable, and clear when read.
// - Receive-error counter adds one per carrier holding an invalid symbol, once per carrier.
// - Receive-error counter ignores errors during collision and sticks at its maximum.
// - PCS bit 12 bypasses the 4B/5B encoder and decoder.
// - PCS bit 11 makes the receive clock free-running, else alignment-adjusted.
// - PCS bit 10 selects transmit true-quiet mode.
// - PCS bit 9 forces signal detect active.
// - PCS bit 8 selects enhanced signal detect; register resets to 0100h.
// - PCS bit 5 forces good 100 Mb/s link, ORed with the MAC force input.
// - PCS bit 2 bypasses the NRZI coding stage.
// - Remote fault event comes from the partner's autoneg remote fault report.
`timescale 1ns/100ps
module phyirq_regs
	import phyirq_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	// Register access port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_rd,
	input  wire logic        i_reg_wr,
	input  wire logic [15:0] i_reg_wdata,
	output logic      [15:0] o_reg_rdata,
	output logic             o_reg_rvalid,
	// Status and events from the receive/transmit path
	input  wire logic        i_link_status,
	input  wire logic        i_jabber_detect,
	input  wire logic        i_remote_fault,
	input  wire logic        i_autoneg_complete,
	input  wire logic        i_false_carrier,
	input  wire logic        i_carrier_valid,
	input  wire logic        i_rx_symbol_error,
	input  wire logic        i_collision,
	input  wire logic        i_signal_detect_raw,
	input  wire logic        i_mac_fast_link_force_in,
	// Interrupt
	output logic             o_interrupt_pending_flag,
	// PCS controls
	output logic             o_block_code_bypass,
	output logic             o_rx_clock_free_run,
	output logic             o_true_quiet_enable,
	output logic             o_signal_detect_force,
	output logic             o_signal_detect_algorithm,
	output logic             o_signal_detect,
	output logic             o_fast_link_force,
	output logic             o_nrzi_bypass
);

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		addr_hit = (addr == ofs);
	endfunction : addr_hit

	// Counters sit in the low byte; the upper byte reads zero
	function automatic logic [15:0] counter_word(input logic [CNT_WIDTH-1:0] count);
		counter_word = {8'h00, count};
	endfunction : counter_word

	logic wr_int_control;
	logic wr_status_mask;
	logic wr_false_carrier;
	logic wr_rx_error;
	logic wr_pcs_config;
	logic rd_status_mask;
	logic rd_false_carrier;
	logic rd_rx_error;

	assign wr_int_control   = i_reg_wr & addr_hit(i_reg_addr, OFS_INT_CONTROL);
	assign wr_status_mask   = i_reg_wr & addr_hit(i_reg_addr, OFS_INT_STATUS_MASK);
	assign wr_false_carrier = i_reg_wr & addr_hit(i_reg_addr, OFS_FALSE_CARRIER);
	assign wr_rx_error      = i_reg_wr & addr_hit(i_reg_addr, OFS_RX_ERROR);
	assign wr_pcs_config    = i_reg_wr & addr_hit(i_reg_addr, OFS_PCS_CONFIG);
	assign rd_status_mask   = i_reg_rd & addr_hit(i_reg_addr, OFS_INT_STATUS_MASK);
	assign rd_false_carrier = i_reg_rd & addr_hit(i_reg_addr, OFS_FALSE_CARRIER);
	assign rd_rx_error      = i_reg_rd & addr_hit(i_reg_addr, OFS_RX_ERROR);

	// ****************************************
	// Stored registers
	// ****************************************
	logic [15:0] int_control;
	logic [15:0] status_mask;
	logic [15:0] pcs_config;
	logic        interrupt_pending_flag;

	// Only the enable and test bits are stored
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			int_control <= RST_INT_CONTROL;
		end else if (wr_int_control) begin
			int_control <= i_reg_wdata & WMASK_INT_CONTROL;
		end
	end

	// Only the mask field is stored here; the pending flag lives apart
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			status_mask <= RST_INT_STATUS_MASK;
		end else if (wr_status_mask) begin
			status_mask <= i_reg_wdata & WMASK_STATUS_MASK;
		end
	end

	// Reset value selects the enhanced signal detect
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pcs_config <= RST_PCS_CONFIG;
		end else if (wr_pcs_config) begin
			pcs_config <= i_reg_wdata & WMASK_PCS_CONFIG;
		end
	end

	logic event_interrupt_enable;
	logic test_interrupt_force;
	logic [NUM_SOURCES-1:0] source_mask;

	assign event_interrupt_enable = int_control[BIT_EVENT_INT_ENABLE];
	assign test_interrupt_force   = int_control[BIT_TEST_INT_FORCE];
	assign source_mask            = status_mask[BIT_MASK_HI:BIT_MASK_LO];

	// ****************************************
	// Event detection
	// ****************************************
	localparam logic [3:0] STATUS_BOTH_EDGES = 4'b0001;

	logic [3:0] status_level;
	logic [3:0] status_event;

	// Link changes on either edge; the others on entering their state
	assign status_level = {i_autoneg_complete, i_remote_fault, i_jabber_detect, i_link_status};

	phyirq_edge_detect #(
		.WIDTH      (4),
		.BOTH_EDGES (STATUS_BOTH_EDGES)
	) u_status_edges (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_level   (status_level),
		.o_event   (status_event)
	);

	// One pulse per status source
	logic link_change_event;
	logic jabber_event;
	logic remote_fault_event;
	logic autoneg_done_event;

	assign link_change_event  = status_event[0];
	assign jabber_event       = status_event[1];
	assign remote_fault_event = status_event[2];
	assign autoneg_done_event = status_event[3];

	// ****************************************
	// Event counters
	// ****************************************
	logic                 rx_error_counted;
	logic                 rx_error_seen;
	logic                 rx_error_inc;
	logic [CNT_WIDTH-1:0] false_carrier_count;
	logic [CNT_WIDTH-1:0] rx_error_count;
	logic                 false_carrier_half;
	logic                 rx_error_half;

	// A bad symbol inside a valid carrier
	assign rx_error_seen = i_carrier_valid & i_rx_symbol_error;

	// One count per carrier, none while colliding
	assign rx_error_inc = rx_error_seen & ~i_collision & ~rx_error_counted;

	// Re-armed only when the carrier drops
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rx_error_counted <= 1'b0;
		end else if (!i_carrier_valid) begin
			rx_error_counted <= 1'b0;
		end else if (rx_error_inc) begin
			rx_error_counted <= 1'b1;
		end
	end

	phyirq_sat_counter u_false_carrier_counter (
		.i_mclk       (i_mclk),
		.i_sys_rst    (i_sys_rst),
		.i_inc        (i_false_carrier),
		.i_wr         (wr_false_carrier),
		.i_wdata      (i_reg_wdata[CNT_WIDTH-1:0]),
		.i_rd_clear   (rd_false_carrier),
		.o_count      (false_carrier_count),
		.o_half_event (false_carrier_half)
	);

	phyirq_sat_counter u_receive_error_counter (
		.i_mclk       (i_mclk),
		.i_sys_rst    (i_sys_rst),
		.i_inc        (rx_error_inc),
		.i_wr         (wr_rx_error),
		.i_wdata      (i_reg_wdata[CNT_WIDTH-1:0]),
		.i_rd_clear   (rd_rx_error),
		.o_count      (rx_error_count),
		.o_half_event (rx_error_half)
	);

	// ****************************************
	// Interrupt pending flag
	// ****************************************
	logic [NUM_SOURCES-1:0] source_event;
	logic                   event_hit;
	logic                   test_hit;
	logic                   next_pending;
	logic                   pend_set;
	logic                   pend_clear;

	always_comb begin
		source_event                = '0;
		source_event[SRC_LINK]      = link_change_event;
		source_event[SRC_JABBER]    = jabber_event;
		source_event[SRC_REM_FAULT] = remote_fault_event;
		source_event[SRC_AN_DONE]   = autoneg_done_event;
		source_event[SRC_FC_HALF]   = false_carrier_half;
		source_event[SRC_RX_HALF]   = rx_error_half;
	end

	assign event_hit = event_interrupt_enable & |(source_event & ~source_mask);
	// Read ends at the edge that takes it, whatever the enable
	assign test_hit  = test_interrupt_force & i_reg_rd;

	assign pend_set   = event_hit | test_hit;
	assign pend_clear = rd_status_mask;

	// A new interrupt beats the clearing read
	always_comb begin
		next_pending = interrupt_pending_flag;
		if (pend_clear) begin
			next_pending = 1'b0;
		end
		if (pend_set) begin
			next_pending = 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			interrupt_pending_flag <= 1'b0;
		end else begin
			interrupt_pending_flag <= next_pending;
		end
	end

	assign o_interrupt_pending_flag = interrupt_pending_flag;

	// ****************************************
	// Read data
	// ****************************************
	logic [15:0] read_value;

	always_comb begin
		case (i_reg_addr)
			OFS_INT_CONTROL: begin
				read_value = int_control;
			end
			OFS_INT_STATUS_MASK: begin
				read_value = status_mask;
				read_value[BIT_PENDING_FLAG] = interrupt_pending_flag;
			end
			OFS_FALSE_CARRIER: begin
				read_value = counter_word(false_carrier_count);
			end
			OFS_RX_ERROR: begin
				read_value = counter_word(rx_error_count);
			end
			OFS_PCS_CONFIG: begin
				read_value = pcs_config;
			end
			// Unmapped offsets read as zero
			default: begin
				read_value = 16'h0000;
			end
		endcase
	end

	// Read data holds until the next read
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_reg_rdata <= 16'h0000;
		end else if (i_reg_rd) begin
			o_reg_rdata <= read_value;
		end
	end

	// One-cycle strobe marking fresh read data
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
		end
	end

	// ****************************************
	// PCS controls
	// ****************************************
	// Forced signal detect overrides the raw detector
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_signal_detect <= 1'b0;
		end else begin
			o_signal_detect <= i_signal_detect_raw | pcs_config[BIT_SD_FORCE];
		end
	end

	// Either the register bit or the MAC can force the 100 Mb/s link up
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_fast_link_force <= 1'b0;
		end else begin
			o_fast_link_force <= pcs_config[BIT_FAST_LINK_FORCE]
			                     | i_mac_fast_link_force_in;
		end
	end

	assign o_block_code_bypass       = pcs_config[BIT_BLOCK_CODE_BYPASS];
	assign o_rx_clock_free_run       = pcs_config[BIT_RX_CLOCK_FREE];
	assign o_true_quiet_enable       = pcs_config[BIT_TRUE_QUIET];
	assign o_signal_detect_force     = pcs_config[BIT_SD_FORCE];
	assign o_signal_detect_algorithm = pcs_config[BIT_SD_ALGORITHM];
	assign o_nrzi_bypass             = pcs_config[BIT_NRZI_BYPASS];

endmodule : phyirq_regs

//--- rtl/phyirq_pkg.sv
// Constants shared by the interrupt, error counter and PCS configuration register bank
package phyirq_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0]  OFS_INT_CONTROL     = 8'hC4;
	localparam logic [7:0]  OFS_INT_STATUS_MASK = 8'hC8;
	localparam logic [7:0]  OFS_FALSE_CARRIER   = 8'hD0;
	localparam logic [7:0]  OFS_RX_ERROR        = 8'hD4;
	localparam logic [7:0]  OFS_PCS_CONFIG      = 8'hD8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_INT_CONTROL     = 16'h0000;
	localparam logic [15:0] RST_INT_STATUS_MASK = 16'h0000;
	localparam logic [7:0]  RST_COUNTER         = 8'h00;
	localparam logic [15:0] RST_PCS_CONFIG      = 16'h0100;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_EVENT_INT_ENABLE   = 1;
	localparam int BIT_TEST_INT_FORCE     = 0;
	localparam int BIT_PENDING_FLAG       = 15;
	localparam int BIT_MASK_HI            = 14;
	localparam int BIT_MASK_LO            = 9;
	localparam int BIT_BLOCK_CODE_BYPASS  = 12;
	localparam int BIT_RX_CLOCK_FREE      = 11;
	localparam int BIT_TRUE_QUIET         = 10;
	localparam int BIT_SD_FORCE           = 9;
	localparam int BIT_SD_ALGORITHM       = 8;
	localparam int BIT_FAST_LINK_FORCE    = 5;
	localparam int BIT_NRZI_BYPASS        = 2;

	// Writable bits of each register; the rest read zero, except the pending flag at status bit 15
	localparam logic [15:0] WMASK_INT_CONTROL   = 16'h0003;
	localparam logic [15:0] WMASK_STATUS_MASK   = 16'h7E00;
	localparam logic [15:0] WMASK_PCS_CONFIG    = 16'h1F24;

	// ****************************************
	// Event sources, in mask-bit order (bit 0 = mask bit 9)
	// ****************************************
	localparam int NUM_SOURCES   = 6;
	localparam int SRC_RX_HALF   = 0;
	localparam int SRC_FC_HALF   = 1;
	localparam int SRC_AN_DONE   = 2;
	localparam int SRC_REM_FAULT = 3;
	localparam int SRC_JABBER    = 4;
	localparam int SRC_LINK      = 5;

	// ****************************************
	// Counter limits
	// ****************************************
	localparam int          CNT_WIDTH    = 8;
	localparam logic [7:0]  CNT_MAX      = 8'hFF;
	localparam int          CNT_HALF_BIT = 7;

endpackage : phyirq_pkg

//--- rtl/phyirq_sat_counter.sv
// Saturating 8-bit event counter, writable, cleared by a read
`timescale 1ns/100ps
module phyirq_sat_counter
	import phyirq_pkg::*;
(
	input  wire logic                 i_mclk,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_inc,
	input  wire logic                 i_wr,
	input  wire logic [CNT_WIDTH-1:0] i_wdata,
	input  wire logic                 i_rd_clear,
	output logic      [CNT_WIDTH-1:0] o_count,
	output logic                      o_half_event
);

	logic [CNT_WIDTH-1:0] next_count;

	always_comb begin
		next_count = o_count;
		if (i_wr) begin
			next_count = i_wdata;
		end else if (i_rd_clear) begin
			// An event in the clearing cycle survives as a count of one
			next_count = i_inc ? RST_COUNTER + 8'h01 : RST_COUNTER;
		end else if (i_inc && o_count != CNT_MAX) begin
			next_count = o_count + 8'h01;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_count <= RST_COUNTER;
		end else begin
			o_count <= next_count;
		end
	end

	// Half-full when the top bit rises
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_half_event <= 1'b0;
		end else begin
			o_half_event <= next_count[CNT_HALF_BIT] & ~o_count[CNT_HALF_BIT];
		end
	end

endmodule : phyirq_sat_counter

//--- rtl/phyirq_edge_detect.sv
// Turns status levels into one-cycle event pulses
`timescale 1ns/100ps
module phyirq_edge_detect
	import phyirq_pkg::*;
#(
	parameter int              WIDTH     = 4,
	parameter logic [WIDTH-1:0] BOTH_EDGES = '0
)
(
	input  wire logic             i_mclk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_level,
	output logic      [WIDTH-1:0] o_event
);

	logic [WIDTH-1:0] level_q;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			// Track the pins during reset so no false edge follows it
			level_q <= i_level;
		end else begin
			level_q <= i_level;
		end
	end

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_edge
			assign o_event[g] = BOTH_EDGES[g] ? (i_level[g] ^ level_q[g])
			                                  : (i_level[g] & ~level_q[g]);
		end
	endgenerate

endmodule : phyirq_edge_detect

//--- verif/phyirq_regs_asserts.sv
// Port-level checker for the interrupt, counter and PCS register bank
`timescale 1ns/100ps
module phyirq_chk
	import phyirq_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_sys_rst,
	input wire logic [7:0]  i_reg_addr,
	input wire logic        i_reg_rd,
	input wire logic        i_reg_wr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic [15:0] o_reg_rdata,
	input wire logic        i_signal_detect_raw,
	input wire logic        i_mac_fast_link_force_in,
	input wire logic        o_interrupt_pending_flag,
	input wire logic        o_block_code_bypass,
	input wire logic        o_rx_clock_free_run,
	input wire logic        o_true_quiet_enable,
	input wire logic        o_signal_detect_force,
	input wire logic        o_signal_detect_algorithm,
	input wire logic        o_signal_detect,
	input wire logic        o_fast_link_force,
	input wire logic        o_nrzi_bypass
);
	logic        event_interrupt_enable_q;
	logic        test_interrupt_force_q;
	logic [15:0] pcs_q;
	logic        trd;
	logic        sd_in;
	logic        flk_in;
	logic        cnt_rd;
	logic        mapped;
	assign trd    = test_interrupt_force_q & i_reg_rd;
	assign sd_in  = i_signal_detect_raw | pcs_q[9];
	assign flk_in = i_mac_fast_link_force_in | pcs_q[5];
	assign cnt_rd = i_reg_rd && (i_reg_addr == OFS_FALSE_CARRIER || i_reg_addr == OFS_RX_ERROR);
	assign mapped = i_reg_addr inside {OFS_INT_CONTROL, OFS_INT_STATUS_MASK, OFS_FALSE_CARRIER,
		OFS_RX_ERROR, OFS_PCS_CONFIG};

	// ********
	// Shadow copies of written control bits
	// ********
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			event_interrupt_enable_q <= 1'b0;
			test_interrupt_force_q  <= 1'b0;
			pcs_q   <= RST_PCS_CONFIG;
		end else if (i_reg_wr && i_reg_addr == OFS_INT_CONTROL) begin
			event_interrupt_enable_q <= i_reg_wdata[1];
			test_interrupt_force_q  <= i_reg_wdata[0];
		end else if (i_reg_wr && i_reg_addr == OFS_PCS_CONFIG) begin
			pcs_q <= i_reg_wdata & WMASK_PCS_CONFIG;
		end
	end

	// ********
	// Assertions
	// ********
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	sequence s_test_rd;
		i_reg_rd && test_interrupt_force_q;
	endsequence
	sequence s_stat_rd;
		i_reg_rd && i_reg_addr == OFS_INT_STATUS_MASK;
	endsequence

	test_int_a: assert property (s_test_rd |=> o_interrupt_pending_flag)
		else $error("test interrupt not raised");
	event_gate_a: assert property ($rose(o_interrupt_pending_flag) |->
		$past(event_interrupt_enable_q) || $past(trd))
		else $error("pending set while events disabled");
	pend_hold_a: assert property (o_interrupt_pending_flag &&
		!(i_reg_rd && i_reg_addr == OFS_INT_STATUS_MASK) |=> o_interrupt_pending_flag)
		else $error("pending dropped without status read");
	stat_read_a: assert property (s_stat_rd ##0 o_interrupt_pending_flag |=>
		o_reg_rdata[15])
		else $error("status read lost pending bit");
	ctl_read_a: assert property (i_reg_rd && i_reg_addr == OFS_INT_CONTROL |=>
		o_reg_rdata == {14'h0000, event_interrupt_enable_q, test_interrupt_force_q})
		else $error("control read wrong");
	unmapped_read_a: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	cnt_upper_a: assert property (cnt_rd |=> o_reg_rdata[15:8] == 8'h00)
		else $error("counter upper bits not zero");
	pcs_out_a: assert property ({o_block_code_bypass, o_rx_clock_free_run,
		o_true_quiet_enable, o_signal_detect_force, o_signal_detect_algorithm,
		o_nrzi_bypass} == {pcs_q[12:8], pcs_q[2]})
		else $error("PCS control output wrong");
	sig_detect_a: assert property (!$past(i_sys_rst) |-> o_signal_detect == $past(sd_in))
		else $error("signal detect wrong");
	fast_link_a: assert property (!$past(i_sys_rst) |-> o_fast_link_force == $past(flk_in))
		else $error("fast link force wrong");
endmodule : phyirq_chk

bind phyirq_regs phyirq_chk u_chk (
	.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
	.i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
	.i_signal_detect_raw(i_signal_detect_raw),
	.i_mac_fast_link_force_in(i_mac_fast_link_force_in),
	.o_interrupt_pending_flag(o_interrupt_pending_flag),
	.o_block_code_bypass(o_block_code_bypass), .o_rx_clock_free_run(o_rx_clock_free_run),
	.o_true_quiet_enable(o_true_quiet_enable), .o_signal_detect_force(o_signal_detect_force),
	.o_signal_detect_algorithm(o_signal_detect_algorithm), .o_signal_detect(o_signal_detect),
	.o_fast_link_force(o_fast_link_force), .o_nrzi_bypass(o_nrzi_bypass)
);

//--- verif/tb.sv
// Self-checking bench for the interrupt, counter and PCS register bank
`timescale 1ns/100ps
module tb;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic        ren = 1'b0;
	logic        wen = 1'b0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic        rvalid;
	logic [3:0]  src = 4'h0;
	logic        fc = 1'b0;
	logic        cv = 1'b0;
	logic        serr = 1'b0;
	logic        col = 1'b0;
	logic        sdr = 1'b0;
	logic        macf = 1'b0;
	logic        pend;
	wire  [7:0]  pcs_o;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;

	always #2.5 mclk = ~mclk;

	phyirq_regs DUT (
		.i_mclk(mclk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_rd(ren),
		.i_reg_wr(wen), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_link_status(src[0]), .i_jabber_detect(src[1]), .i_remote_fault(src[2]),
		.i_autoneg_complete(src[3]), .i_false_carrier(fc), .i_carrier_valid(cv),
		.i_rx_symbol_error(serr), .i_collision(col), .i_signal_detect_raw(sdr),
		.i_mac_fast_link_force_in(macf), .o_interrupt_pending_flag(pend),
		.o_block_code_bypass(pcs_o[7]), .o_rx_clock_free_run(pcs_o[6]),
		.o_true_quiet_enable(pcs_o[5]), .o_signal_detect_force(pcs_o[4]),
		.o_signal_detect_algorithm(pcs_o[3]), .o_signal_detect(pcs_o[2]),
		.o_fast_link_force(pcs_o[1]), .o_nrzi_bypass(pcs_o[0])
	);

	// ********
	// Shared bus and compare tasks
	// ********
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wen   <= 1'b1;
		@(posedge mclk);
		wen <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk);
		addr <= a;
		ren  <= 1'b1;
		@(posedge mclk);
		ren <= 1'b0;
		@(posedge mclk);
		chk(rvalid, 1'b1);
		chk(rdata, exp);
	endtask : rd
	task automatic pchk(input logic e);
		repeat (4) @(posedge mclk);
		chk(pend, e);
	endtask : pchk
	task automatic fcp();
		fc <= 1'b1;
		@(posedge mclk);
		fc <= 1'b0;
		@(posedge mclk);
	endtask : fcp
	// One carrier with two bad symbols, optionally under collision
	task automatic carrier(input logic c);
		cv  <= 1'b1;
		col <= c;
		repeat (2) begin
			@(posedge mclk);
			serr <= 1'b1;
			@(posedge mclk);
			serr <= 1'b0;
		end
		@(posedge mclk);
		cv  <= 1'b0;
		col <= 1'b0;
		@(posedge mclk);
	endtask : carrier

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		rd(8'hC4, 16'h0000);
		rd(8'hC8, 16'h0000);
		rd(8'hD0, 16'h0000);
		rd(8'hD4, 16'h0000);
		rd(8'hD8, 16'h0100);
		rd(8'hCC, 16'h0000);
		chk(pcs_o, 8'h08);
		$display("reset values done");
	endtask : t_reset
	task automatic t_reserved();
		wr(8'hC4, 16'hFFFF);
		rd(8'hC4, 16'h0003);
		wr(8'hC4, 16'h0000);
		rd(8'hC8, 16'h8000);
		chk(pend, 1'b0);
		wr(8'hC8, 16'hFFFF);
		rd(8'hC8, 16'h7E00);
		wr(8'hD0, 16'hFF12);
		rd(8'hD0, 16'h0012);
		rd(8'hD0, 16'h0000);
		wr(8'hD4, 16'hFF34);
		rd(8'hD4, 16'h0034);
		rd(8'hD4, 16'h0000);
		wr(8'hCC, 16'hFFFF);
		rd(8'hCC, 16'h0000);
		$display("reserved bits done");
	endtask : t_reserved
	task automatic t_pcs();
		wr(8'hD8, 16'hFFFF);
		rd(8'hD8, 16'h1F24);
		chk(pcs_o, 8'hFF);
		wr(8'hD8, 16'h0000);
		rd(8'hD8, 16'h0000);
		chk(pcs_o, 8'h00);
		sdr  <= 1'b1;
		macf <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(pcs_o, 8'h06);
		sdr  <= 1'b0;
		macf <= 1'b0;
		$display("PCS config done");
	endtask : t_pcs
	task automatic t_test_int();
		wr(8'hC4, 16'h0001);
		chk(pend, 1'b0);
		rd(8'hD8, 16'h0000);
		chk(pend, 1'b1);
		rd(8'hC8, 16'hFE00);
		chk(pend, 1'b1);
		wr(8'hC4, 16'h0000);
		rd(8'hC8, 16'hFE00);
		chk(pend, 1'b0);
		$display("test interrupt done");
	endtask : t_test_int
	task automatic t_events();
		wr(8'hC4, 16'h0002);
		for (int i = 0; i < 4; i++) begin
			wr(8'hC8, 16'h4000 >> i);
			src[i] <= 1'b1;
			pchk(1'b0);
			src[i] <= 1'b0;
			pchk(1'b0);
			wr(8'hC8, 16'h0000);
			src[i] <= 1'b1;
			pchk(1'b1);
			rd(8'hC8, 16'h8000);
			chk(pend, 1'b0);
			src[i] <= 1'b0;
			pchk(i == 0);
			rd(8'hC8, (i == 0) ? 16'h8000 : 16'h0000);
		end
		wr(8'hC4, 16'h0000);
		src <= 4'hF;
		pchk(1'b0);
		src <= 4'h0;
		pchk(1'b0);
		$display("event sources done");
	endtask : t_events
	task automatic t_counters();
		wr(8'hC4, 16'h0002);
		wr(8'hC8, 16'h0000);
		wr(8'hD0, 16'h007F);
		fcp();
		pchk(1'b1);
		rd(8'hD0, 16'h0080);
		rd(8'hD0, 16'h0000);
		rd(8'hC8, 16'h8000);
		wr(8'hC8, 16'h0400);
		wr(8'hD0, 16'h00FE);
		repeat (3) fcp();
		rd(8'hD0, 16'h00FF);
		rd(8'hC8, 16'h0400);
		wr(8'hC8, 16'h0000);
		wr(8'hD4, 16'h007F);
		carrier(1'b0);
		pchk(1'b1);
		rd(8'hD4, 16'h0080);
		rd(8'hC8, 16'h8000);
		carrier(1'b1);
		rd(8'hD4, 16'h0000);
		wr(8'hC8, 16'h0200);
		wr(8'hD4, 16'h00FF);
		carrier(1'b0);
		rd(8'hD4, 16'h00FF);
		rd(8'hC8, 16'h0200);
		$display("event counters done");
	endtask : t_counters

	task automatic results();
		$display("checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_reserved();
		t_pcs();
		t_test_int();
		t_events();
		t_counters();
		results();
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			$display("[ERR] %0t: run too long", $time);
			results();
		end
	end
endmodule : tb
